// file: dest_set_pkg.sv
// Package: register map, field layout and carriers of the destination set view
package dest_set_pkg;

   // ----------------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------------
   localparam int          ADDR_W          = 12;
   localparam int          SET_SEL_LSB     = 5;   // 32-byte stride per set
   localparam int          REG_SEL_LSB     = 2;
   localparam int          GLOBAL_BIT      = 11;  // Set region below 0x800
   localparam logic [2:0]  REG_COUNT       = 3'h0;
   localparam logic [2:0]  REG_DEST_ADDR   = 3'h1;
   localparam logic [2:0]  REG_ARRAY_INDEX = 3'h2;
   localparam logic [2:0]  REG_PROT_PROXY  = 3'h3;
   localparam logic [2:0]  REG_CNT_RELOAD  = 3'h4;
   localparam logic [2:0]  REG_SRC_REF     = 3'h5;
   localparam logic [11:0] STATUS_ADDR     = 12'h800;
   localparam logic [11:0] CONTROL_ADDR    = 12'h804;

   // ----------------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------------
   localparam int          ARRAYS_LSB      = 16;
   localparam int          BYTES_LSB       = 0;
   localparam int          DEST_OFS_LSB    = 16;
   localparam int          PRIVILEGE_LEVEL_BIT        = 8;
   localparam int          PRIVILEGE_IDENTIFIER_LSB      = 0;
   localparam int          OCC_LSB         = 0;
   localparam int          BUSY_BIT        = 16;
   localparam int          ENABLE_BIT      = 0;
   localparam logic        ENABLE_RST      = 1'b0;
   localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
   localparam int          DEPTH_DEFAULT   = 4;

   // ----------------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] dest_addr;
      logic [15:0] arrays;
      logic [15:0] bytes;
      logic [15:0] dest_ofs;
      logic        privilege_level;
      logic [3:0]  privilege_identifier;
   } submit_s;

   typedef struct packed {
      logic [15:0] arrays_remaining;
      logic [15:0] bytes_remaining;
      logic [31:0] write_address;
      logic [15:0] dest_array_offset;
      logic        privilege_level;
      logic [3:0]  privilege_identifier;
      logic [15:0] byte_count_reload;
      logic [31:0] array_start;
   } set_s;

   typedef struct packed {
      logic [31:0] addr;
      logic        privilege_level;
      logic [3:0]  privilege_identifier;
   } wcmd_s;

endpackage

// file: dest_set_view.sv
// Destination register sets, write command engine and Avalon-MM view
// Functional notes
// R1: Sets numbered zero up to depth parameter, each holding one transfer.
// R2: Count upper half shows arrays still to be written.
// R3: Count lower half shows bytes left in current array.
// R4: Address register tracks writes; after completion holds last write.
// R5: Index upper half is destination array offset; lower half reads zero.
// R6: Proxy bit 8 holds privilege level latched at submission.
// R7: Proxy bits 3..0 hold privilege identifier latched at submission.
// R8: Every write command carries the latched privilege level and identifier.
// R9: Reload keeps programmed byte count, restores it per array; upper zero.
// R10: Set registers read-only, zero after reset, writes ignored.
// R11: Source reference register always reads zero.
// R12: Byte count exhausted reloads, decrements arrays, advances array start.
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module dest_set_view
   import dest_set_pkg::*;
#(
   parameter int DEPTH = DEPTH_DEFAULT    // dest_set_depth
)(
   input  wire logic              clk,            // 200 MHz clock
   input  wire logic              rst_n,          // Async reset, active low
   input  wire logic [ADDR_W-1:0] address,        // Avalon byte address
   input  wire logic              read,           // Avalon read
   input  wire logic              write,          // Avalon write
   input  wire logic [31:0]       writedata,      // Avalon write data
   input  wire logic [3:0]        byteenable,     // Avalon byte enables
   output logic      [31:0]       readdata,       // Avalon read data
   output logic                   waitrequest,    // Avalon wait
   input  wire logic              submit_valid,   // New transfer request
   output logic                   submit_ready,   // A set is free
   input  wire submit_s           submit_req,     // Request parameters
   output logic                   wcmd_valid,     // Write command valid
   input  wire logic              wcmd_ready,     // Endpoint accepts
   output wcmd_s                  wcmd            // Write command
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [PW-1:0] next_slot(input logic [PW-1:0] p);
      next_slot = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   function automatic logic [31:0] set_word(input set_s s,
                                            input logic [2:0] r);
      set_word = WORD_ZERO;
      if (r == REG_COUNT)
      begin
         set_word[ARRAYS_LSB +: 16] = s.arrays_remaining;      // R2
         set_word[BYTES_LSB +: 16]  = s.bytes_remaining;       // R3
      end
      else if (r == REG_DEST_ADDR)
         set_word = s.write_address;                          // R4
      else if (r == REG_ARRAY_INDEX)
         set_word[DEST_OFS_LSB +: 16] = s.dest_array_offset;   // R5
      else if (r == REG_PROT_PROXY)
      begin
         set_word[PRIVILEGE_LEVEL_BIT] = s.privilege_level;               // R6
         set_word[PRIVILEGE_IDENTIFIER_LSB +: 4] = s.privilege_identifier;   // R7
      end
      else if (r == REG_CNT_RELOAD)
         set_word[BYTES_LSB +: 16] = s.byte_count_reload;      // R9
   endfunction

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   set_s [DEPTH-1:0] sets_r, sets_nxt;
   logic [PW-1:0]    wr_ptr_r, wr_ptr_nxt;
   logic [PW-1:0]    rd_ptr_r, rd_ptr_nxt;
   logic [CW-1:0]    cnt_r, cnt_nxt;
   logic             enable_r, enable_nxt;
   logic             ack_r, ack_nxt;
   logic [31:0]      rdata_r, rdata_nxt;
   wcmd_s            buf_r [2];
   wcmd_s            buf_nxt [2];
   logic             bwr_r, bwr_nxt, brd_r, brd_nxt;
   logic [1:0]       arrays_remaining_r, arrays_remaining_nxt;
   logic             buf_in_ready;
   logic             issue;
   logic             retire;
   logic             submit;
   set_s             head;
   wcmd_s            cmd_in;

   assign head         = sets_r[rd_ptr_r];
   assign submit_ready = (cnt_r != FULL_CNT);                  // R1
   assign submit       = submit_valid && submit_ready;
   assign buf_in_ready = (arrays_remaining_r != 2'h2);

   // ----------------------------------------------------------------------
   // Set queue and write engine
   // ----------------------------------------------------------------------
   always_comb
   begin
      sets_nxt   = sets_r;
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      issue      = 1'b0;
      retire     = 1'b0;
      cmd_in.addr                 = head.write_address;
      cmd_in.privilege_level      = head.privilege_level;      // R8
      cmd_in.privilege_identifier = head.privilege_identifier; // R8
      if (submit)
      begin
         // Identity latched here and never touched again       // R6 R7
         sets_nxt[wr_ptr_r].arrays_remaining  = submit_req.arrays;
         sets_nxt[wr_ptr_r].bytes_remaining   = submit_req.bytes;
         sets_nxt[wr_ptr_r].write_address     = submit_req.dest_addr;
         sets_nxt[wr_ptr_r].dest_array_offset = submit_req.dest_ofs;
         sets_nxt[wr_ptr_r].privilege_level   =
            submit_req.privilege_level;
         sets_nxt[wr_ptr_r].privilege_identifier =
            submit_req.privilege_identifier;
         sets_nxt[wr_ptr_r].byte_count_reload = submit_req.bytes; // R9
         sets_nxt[wr_ptr_r].array_start       = submit_req.dest_addr;
         wr_ptr_nxt = next_slot(wr_ptr_r);
      end
      if (enable_r && cnt_r != '0)
      begin
         // Empty requests retire without a single command
         if (head.arrays_remaining == '0 || head.bytes_remaining == '0)
            retire = 1'b1;
         else if (buf_in_ready)
         begin
            issue = 1'b1;
            if (head.bytes_remaining > 16'h0001)
            begin
               sets_nxt[rd_ptr_r].bytes_remaining =
                  head.bytes_remaining - 16'h0001;             // R3
               sets_nxt[rd_ptr_r].write_address =
                  head.write_address + 32'h0000_0001;          // R4
            end
            else if (head.arrays_remaining > 16'h0001)
            begin
               sets_nxt[rd_ptr_r].bytes_remaining =
                  head.byte_count_reload;                      // R9 R12
               sets_nxt[rd_ptr_r].arrays_remaining =
                  head.arrays_remaining - 16'h0001;            // R2 R12
               sets_nxt[rd_ptr_r].array_start = head.array_start +
                  {16'h0000, head.dest_array_offset};          // R12
               sets_nxt[rd_ptr_r].write_address = head.array_start +
                  {16'h0000, head.dest_array_offset};          // R12
            end
            else
            begin
               // Address left on the last write issued          // R4
               sets_nxt[rd_ptr_r].bytes_remaining  = 16'h0000;
               sets_nxt[rd_ptr_r].arrays_remaining = 16'h0000;
               retire = 1'b1;                                  // R12
            end
         end
      end
      if (retire)
         rd_ptr_nxt = next_slot(rd_ptr_r);
      cnt_nxt = cnt_r + CW'(submit) - CW'(retire);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sets_r   <= '0;                                       // R10
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
      end
      else
      begin
         sets_r   <= sets_nxt;
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         cnt_r    <= cnt_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Two-entry command buffer; a stalled endpoint stalls the engine
   // ----------------------------------------------------------------------
   always_comb
   begin
      buf_nxt  = buf_r;
      bwr_nxt  = bwr_r;
      brd_nxt  = brd_r;
      arrays_remaining_nxt = arrays_remaining_r;
      if (issue)
      begin
         buf_nxt[bwr_r] = cmd_in;                              // R8
         bwr_nxt = ~bwr_r;
      end
      if (wcmd_valid && wcmd_ready)
         brd_nxt = ~brd_r;
      arrays_remaining_nxt = arrays_remaining_r + 2'(issue) - 2'(wcmd_valid && wcmd_ready);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buf_r[0] <= '0;
         buf_r[1] <= '0;
         bwr_r    <= 1'b0;
         brd_r    <= 1'b0;
         arrays_remaining_r   <= 2'h0;
      end
      else
      begin
         buf_r    <= buf_nxt;
         bwr_r    <= bwr_nxt;
         brd_r    <= brd_nxt;
         arrays_remaining_r   <= arrays_remaining_nxt;
      end
   end

   assign wcmd_valid = (arrays_remaining_r != 2'h0);
   assign wcmd       = buf_r[brd_r];

   // ----------------------------------------------------------------------
   // Avalon-MM slave: one wait state on every access
   // ----------------------------------------------------------------------
   always_comb
   begin
      ack_nxt    = (read || write) && !ack_r;
      rdata_nxt  = rdata_r;
      enable_nxt = enable_r;
      if (read && !ack_r)
      begin
         rdata_nxt = WORD_ZERO;
         if (address[1:0] != 2'h0)
            rdata_nxt = WORD_ZERO;
         else if (!address[GLOBAL_BIT])
         begin
            if (address[GLOBAL_BIT-1:SET_SEL_LSB] < (GLOBAL_BIT -
                SET_SEL_LSB)'(DEPTH))
               rdata_nxt = set_word(sets_r[PW'(address[GLOBAL_BIT-1:
                  SET_SEL_LSB])], address[SET_SEL_LSB-1:REG_SEL_LSB]);
         end                                                   // R11
         else if (address == STATUS_ADDR)
         begin
            rdata_nxt[OCC_LSB +: CW] = cnt_r;
            rdata_nxt[BUSY_BIT]      = (cnt_r != '0) || wcmd_valid;
         end
         else if (address == CONTROL_ADDR)
            rdata_nxt[ENABLE_BIT] = enable_r;
      end
      // Set registers have no write path at all              // R10
      // Commit at the edge where waitrequest is low, as the master sees it
      if (write && ack_r && address == CONTROL_ADDR && byteenable[0])
         enable_nxt = writedata[ENABLE_BIT];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_r    <= 1'b0;
         rdata_r  <= WORD_ZERO;
         enable_r <= ENABLE_RST;
      end
      else
      begin
         ack_r    <= ack_nxt;
         rdata_r  <= rdata_nxt;
         enable_r <= enable_nxt;
      end
   end

   assign waitrequest = (read || write) && !ack_r;
   assign readdata    = rdata_r;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   logic rd_done;
   assign rd_done = read && !waitrequest && address[1:0] == 2'h0 &&
                    !address[GLOBAL_BIT];

   sequence s_mid_byte;
      issue && head.bytes_remaining > 16'h0001;
   endsequence

   sequence s_array_end;
      issue && head.bytes_remaining == 16'h0001 &&
      head.arrays_remaining > 16'h0001;
   endsequence

   property p_src_ref_zero;
      @(posedge clk) disable iff (!rst_n)
      rd_done && address[SET_SEL_LSB-1:REG_SEL_LSB] == REG_SRC_REF
      |-> readdata == WORD_ZERO;
   endproperty
   a_src_ref_zero: assert property (p_src_ref_zero) // R11
      else $error("source reference read not zero");

   property p_index_low_zero;
      @(posedge clk) disable iff (!rst_n)
      rd_done && address[SET_SEL_LSB-1:REG_SEL_LSB] == REG_ARRAY_INDEX
      |-> readdata[15:0] == 16'h0000;
   endproperty
   a_index_low_zero: assert property (p_index_low_zero) // R5
      else $error("index low half not zero");

   property p_reload_high_zero;
      @(posedge clk) disable iff (!rst_n)
      rd_done && address[SET_SEL_LSB-1:REG_SEL_LSB] == REG_CNT_RELOAD
      |-> readdata[31:16] == 16'h0000;
   endproperty
   a_reload_high_zero: assert property (p_reload_high_zero) // R9
      else $error("reload upper half not zero");

   property p_proxy_reserved;
      @(posedge clk) disable iff (!rst_n)
      rd_done && address[SET_SEL_LSB-1:REG_SEL_LSB] == REG_PROT_PROXY
      |-> readdata[31:9] == 23'h000000 && readdata[7:4] == 4'h0;
   endproperty
   a_proxy_reserved: assert property (p_proxy_reserved) // R6
      else $error("proxy reserved bits not zero");

   property p_mid_byte;
      @(posedge clk) disable iff (!rst_n)
      s_mid_byte |=> head.bytes_remaining ==
         $past(head.bytes_remaining) - 16'h0001 &&
         head.write_address == $past(head.write_address) + 32'h0000_0001;
   endproperty
   a_mid_byte: assert property (p_mid_byte) // R3
      else $error("byte step wrong");

   property p_array_end;
      @(posedge clk) disable iff (!rst_n)
      s_array_end |=> head.bytes_remaining ==
         $past(head.byte_count_reload) && head.arrays_remaining ==
         $past(head.arrays_remaining) - 16'h0001;
   endproperty
   a_array_end: assert property (p_array_end) // R12
      else $error("array reload wrong");

   property p_cmd_identity;
      @(posedge clk) disable iff (!rst_n)
      issue |=> wcmd_valid && buf_r[$past(bwr_r)].privilege_identifier ==
         $past(head.privilege_identifier);
   endproperty
   a_cmd_identity: assert property (p_cmd_identity) // R8
      else $error("command identity lost");

   property p_ro_sets;
      @(posedge clk) disable iff (!rst_n)
      write && !issue && !submit |=> $stable(sets_r);
   endproperty
   a_ro_sets: assert property (p_ro_sets) // R10
      else $error("write altered a set");

   property p_full_refuse;
      @(posedge clk) disable iff (!rst_n)
      cnt_r == FULL_CNT |=> wr_ptr_r == $past(wr_ptr_r);
   endproperty
   a_full_refuse: assert property (p_full_refuse) // R1
      else $error("submit accepted while full");

endmodule

// file: endpoint_model.sv
// Memory target endpoint that takes write commands, promptly or slowly
`timescale 1ns/1ps
module endpoint_model
   import dest_set_pkg::*;
(
   input  wire logic  clk,        // Controller clock
   input  wire logic  rst_n,      // Async reset, active low
   input  wire logic  stall,      // Hold ready low
   input  wire logic  slow,       // Accept every other cycle
   input  wire logic  wcmd_valid, // Command offered
   output logic       wcmd_ready, // Command accepted
   input  wire wcmd_s wcmd,       // Offered command
   output logic       got_r,      // One command taken last edge
   output wcmd_s      got_cmd_r   // Command taken last edge
);
   // ----------------------------------------------------------------------
   // Acceptance
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wcmd_ready <= 1'b0;
         got_r      <= 1'b0;
         got_cmd_r  <= '0;
      end
      else
      begin
         // Slow mode toggles so the buffer sees both stall and drain
         wcmd_ready <= ~stall & (~slow | ~wcmd_ready);
         got_r      <= wcmd_valid & wcmd_ready;
         got_cmd_r  <= wcmd;
      end
   end
endmodule

// file: test_dest_set_view.sv
// Self-checking bench for the destination set view
`timescale 1ns/1ps
module test_dest_set_view;
   import dest_set_pkg::*;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic [ADDR_W-1:0] address = '0;
   logic              read = 1'b0;
   logic              write = 1'b0;
   logic [31:0]       writedata = '0;
   logic [3:0]        byteenable = 4'hF;
   logic [31:0]       readdata;
   logic              waitrequest;
   logic              submit_valid = 1'b0;
   logic              submit_ready;
   submit_s           submit_req = '0;
   logic              wcmd_valid;
   logic              wcmd_ready;
   wcmd_s             wcmd;
   logic              stall = 1'b0;
   logic              slow = 1'b0;
   logic              got_r;
   wcmd_s             got_cmd_r;
   int                n_mismatch = 0;
   int                samples_checked = 0;
   int                cycles = 0;
   wcmd_s             exp_q[$];
   logic [31:0]       d;

   always #2.5 clk = ~clk;

   dest_set_view #(.DEPTH(4)) i_dut (.clk(clk), .rst_n(rst_n),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .submit_valid(submit_valid),
      .submit_ready(submit_ready), .submit_req(submit_req),
      .wcmd_valid(wcmd_valid), .wcmd_ready(wcmd_ready), .wcmd(wcmd));

   endpoint_model i_ep (.clk(clk), .rst_n(rst_n), .stall(stall),
      .slow(slow), .wcmd_valid(wcmd_valid), .wcmd_ready(wcmd_ready),
      .wcmd(wcmd), .got_r(got_r), .got_cmd_r(got_cmd_r));

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic check(input string what, input logic [63:0] seen,
                        input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   function automatic logic [11:0] sa(input int n, input int r);
      return 12'(n * 32 + r * 4);
   endfunction

   // Request stays up until the edge at which waitrequest is seen low
   task automatic av_access(input logic wr, input logic [11:0] a,
                            input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      read      <= ~wr;
      write     <= wr;
      address   <= a;
      writedata <= wd;
      @(posedge clk);
      while (waitrequest !== 1'b0)
         @(posedge clk);
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [11:0] a,
                         input logic [31:0] exp);
      logic [31:0] v;
      av_access(1'b0, a, 32'h0000_0000, v);
      check(what, v, exp);
   endtask

   task automatic submit(input logic [31:0] a, input logic [15:0] ar,
                         input logic [15:0] by, input logic [15:0] ofs,
                         input logic pl, input logic [3:0] id);
      @(posedge clk);
      submit_valid <= 1'b1;
      submit_req   <= '{dest_addr: a, arrays: ar, bytes: by, dest_ofs: ofs,
                        privilege_level: pl, privilege_identifier: id};
      @(posedge clk);
      while (submit_ready !== 1'b1)
         @(posedge clk);
      submit_valid <= 1'b0;
   endtask

   // ----------------------------------------------------------------------
   // Command scoreboard and timeout
   // ----------------------------------------------------------------------
   always @(posedge clk)
   begin
      cycles++;
      if (got_r === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("extra command", 1, 0);
         else
            check("write command", got_cmd_r, exp_q.pop_front());
      end
      if (cycles == 20000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int r = 0; r < 6; r++)
         rd_chk("reset value", sa(0, r), 32'h0000_0000);
      rd_chk("unmapped", 12'h900, 32'h0000_0000);
      submit(32'h0000_1000, 16'h0002, 16'h0003, 16'h0010, 1'b1, 4'h5);
      rd_chk("count", sa(0, 0), 32'h0002_0003);
      rd_chk("dest address", sa(0, 1), 32'h0000_1000);
      rd_chk("array index", sa(0, 2), 32'h0010_0000);
      rd_chk("proxy", sa(0, 3), 32'h0000_0105);
      rd_chk("reload", sa(0, 4), 32'h0000_0003);
      rd_chk("source ref", sa(0, 5), 32'h0000_0000);
      av_access(1'b1, sa(0, 0), 32'hFFFF_FFFF, d);
      av_access(1'b1, sa(0, 3), 32'hFFFF_FFFF, d);
      rd_chk("count after write", sa(0, 0), 32'h0002_0003);
      rd_chk("proxy after write", sa(0, 3), 32'h0000_0105);
      // A control write with lane 0 off must leave the engine disabled
      byteenable <= 4'h0;
      av_access(1'b1, CONTROL_ADDR, 32'h0000_0001, d);
      byteenable <= 4'hF;
      rd_chk("control lanes off", CONTROL_ADDR, 32'h0000_0000);
      submit(32'h0000_2000, 16'h0001, 16'h0001, 16'hFFFF, 1'b0, 4'hA);
      // Zero in either count retires the set without any command
      submit(32'h0000_3000, 16'h0002, 16'h0000, 16'h0004, 1'b1, 4'hF);
      submit(32'h0000_4000, 16'h0000, 16'h0004, 16'h0004, 1'b0, 4'h0);
      @(negedge clk);
      check("ready when full", submit_ready, 1'b0);
      check("idle before enable", wcmd_valid, 1'b0);
      rd_chk("set1 proxy", sa(1, 3), 32'h0000_000A);
      rd_chk("set1 index", sa(1, 2), 32'hFFFF_0000);
      rd_chk("set3 count", sa(3, 0), 32'h0000_0004);
      rd_chk("set beyond depth", sa(4, 0), 32'h0000_0000);
      for (int a = 0; a < 2; a++)
         for (int b = 0; b < 3; b++)
            exp_q.push_back('{addr: 32'(32'h1000 + a * 16 + b),
                              privilege_level: 1'b1,
                              privilege_identifier: 4'h5});
      exp_q.push_back('{addr: 32'h0000_2000, privilege_level: 1'b0,
                        privilege_identifier: 4'hA});
      stall <= 1'b1;
      av_access(1'b1, CONTROL_ADDR, 32'h0000_0001, d);
      repeat (20) @(posedge clk);
      @(negedge clk);
      check("valid while stalled", wcmd_valid, 1'b1);
      rd_chk("count mid array", sa(0, 0), 32'h0002_0001);
      rd_chk("address mid array", sa(0, 1), 32'h0000_1002);
      rd_chk("status busy", STATUS_ADDR, 32'h0001_0004);
      rd_chk("control enabled", CONTROL_ADDR, 32'h0000_0001);
      @(posedge clk);
      stall <= 1'b0;
      slow  <= 1'b1;
      for (int n = 0; n < 500 && exp_q.size() != 0; n++)
         @(posedge clk);
      check("commands left", exp_q.size(), 0);
      repeat (10) @(posedge clk);
      rd_chk("final count", sa(0, 0), 32'h0000_0000);
      rd_chk("last write address", sa(0, 1), 32'h0000_1012);
      rd_chk("reload kept", sa(0, 4), 32'h0000_0003);
      rd_chk("set1 last address", sa(1, 1), 32'h0000_2000);
      rd_chk("status idle", STATUS_ADDR, 32'h0000_0000);
      give_verdict();
   end
endmodule
